// ===== shared/nad_pkg.sv
// Package: opcodes, field positions, reset values and address widths of the nibble adder
package nad_pkg;
  // ******************************
  // Instruction fields
  // ******************************
  localparam int           INSTR_W        = 16;
  localparam int           OP_HI          = 15;
  localparam int           OP_LO          = 11;
  localparam int           MROW_HI        = 10;
  localparam int           MROW_LO        = 8;
  localparam int           MCOL_HI        = 7;
  localparam int           MCOL_LO        = 4;
  localparam int           LOW_HI         = 3;
  localparam int           LOW_LO         = 0;
  localparam logic [4:0]   OP_ADD_RM      = 5'h00;
  localparam logic [4:0]   OP_ADD_WITH_CARRY_OPERATION_RM     = 5'h02;
  localparam logic [4:0]   OP_ADD_MI      = 5'h10;
  localparam logic [4:0]   OP_ADD_WITH_CARRY_OPERATION_MI     = 5'h12;
  // ******************************
  // Addresses and reset values
  // ******************************
  localparam int           DADDR_W        = 11;
  localparam logic [3:0]   BCD_LIMIT      = 4'h9;
  localparam logic [3:0]   BCD_FIX        = 4'h6;
  localparam logic         CARRY_RST      = 1'b0;
  localparam logic         ZERO_RST       = 1'b0;
  localparam logic [3:0]   NIB_RST        = 4'h0;
  localparam logic [DADDR_W-1:0] ADDR_RST = 11'h000;
  typedef enum logic [1:0] {NAD_IDLE, NAD_READ, NAD_WRITE} nad_state_t;
endpackage

// ===== testbench/nad_checker.sv
// Checker: handshake, write-back and flag relations at the datapath ports
`timescale 1ns/100ps
module nad_checker
  import nad_pkg::*;
(
  input wire logic i_clock, i_sys_rst, i_start, i_compare_flag, o_busy, o_done,
  input wire logic o_mem_we, o_reg_we, o_carry_flag, o_zero_flag,
  input wire logic [INSTR_W-1:0] i_instr,
  input wire logic [3:0] o_mem_wdata
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire [4:0] op = i_instr[OP_HI:OP_LO];
  wire ok = op inside {OP_ADD_RM, OP_ADD_WITH_CARRY_OPERATION_RM, OP_ADD_MI, OP_ADD_WITH_CARRY_OPERATION_MI};
  a_done_latency: assert property (i_start && ok && !o_busy && !o_done |=> o_busy ##1 o_done)
    else $error("done late");
  a_we_in_done: assert property (o_mem_we || o_reg_we |-> o_done)
    else $error("stray write");
  a_cmp_blocks: assert property (o_done && i_compare_flag |-> !o_mem_we && !o_reg_we)
    else $error("write on compare");
  a_reg_dest: assert property (o_done && !i_compare_flag && !op[4] |-> o_reg_we && !o_mem_we)
    else $error("register not written");
  a_mem_dest: assert property (o_done && !i_compare_flag && op[4] |-> o_mem_we && !o_reg_we)
    else $error("memory not written");
  a_zero_clear: assert property (o_mem_we && o_mem_wdata != 4'h0 |-> !o_zero_flag)
    else $error("zero kept");
  a_zero_set: assert property (o_mem_we && o_mem_wdata == 4'h0 |-> o_zero_flag)
    else $error("zero not set");
  a_flags_still: assert property (!o_done |-> $stable({o_carry_flag, o_zero_flag}))
    else $error("flags moved");
endmodule
bind nad_datapath nad_checker nad_checker_i (.i_clock, .i_sys_rst, .i_start, .i_compare_flag,
  .o_busy, .o_done, .o_mem_we, .o_reg_we, .o_carry_flag, .o_zero_flag, .i_instr, .o_mem_wdata);

// ===== testbench/nad_datapath_bench.sv
// Bench: table of additions, then refusal and reset cases
`timescale 1ns/100ps
module nad_datapath_bench;
  import nad_pkg::*;
  typedef struct packed {logic [4:0] op; logic [6:0] m; logic [3:0] r; logic c, d, x;} nad_row_t;
  logic        clk = 0, rst = 1, start = 0, cmp = 0, dec = 0, index_enable_flag = 0, ec = 0, ez = 0;
  logic [15:0] instr = 0;
  logic [3:0]  mrd, rrd, mwd, rwd;
  logic [10:0] ma, ra;
  logic        busy, done, mwe, rwe, cy, z;
  int          num_errors = 0, n_tests = 0, cycles = 0;
  nad_row_t    rows [10] = '{{OP_ADD_RM, 7'h2F, 4'h3, 3'h0}, {OP_ADD_WITH_CARRY_OPERATION_RM, 7'h2E, 4'h4, 3'h0},
    {OP_ADD_MI, 7'h05, 4'hB, 3'h0}, {OP_ADD_MI, 7'h07, 4'h1, 3'h4}, {OP_ADD_MI, 7'h06, 4'hA, 3'h4},
    {OP_ADD_MI, 7'h05, 4'h0, 3'h0}, {OP_ADD_MI, 7'h06, 4'hA, 3'h4}, {OP_ADD_WITH_CARRY_OPERATION_MI, 7'h08, 4'h3, 3'h2},
    {OP_ADD_RM, 7'h2F, 4'h0, 3'h1}, {OP_ADD_WITH_CARRY_OPERATION_MI, 7'h11, 4'h9, 3'h3}};
  nad_datapath nad_datapath_i (.i_clock(clk), .i_sys_rst(rst), .i_start(start), .i_instr(instr),
    .i_compare_flag(cmp), .i_decimal_flag(dec), .i_index_enable_flag(index_enable_flag),
    .i_index_high_nibble(3'h0), .i_index_middle_nibble(4'h1), .i_index_low_nibble(4'h0),
    .i_gpr_pointer_high(3'h0), .i_gpr_pointer_low(4'h4), .i_mem_rdata(mrd), .i_reg_rdata(rrd),
    .o_busy(busy), .o_done(done), .o_mem_addr(ma), .o_mem_we(mwe), .o_mem_wdata(mwd),
    .o_reg_addr(ra), .o_reg_we(rwe), .o_reg_wdata(rwd), .o_carry_flag(cy), .o_zero_flag(z));
  nad_mem_model nad_mem_model_i (.i_clock(clk), .i_mem_addr(ma), .i_reg_addr(ra), .i_mem_we(mwe),
    .i_reg_we(rwe), .i_mem_wdata(mwd), .i_reg_wdata(rwd), .o_mem_rdata(mrd), .o_reg_rdata(rrd));
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (++cycles > 2000) begin
    num_errors++;
    test_done();
  end
  task automatic chk(string n, logic [10:0] e, logic [10:0] s);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // One addition, expectation from operands
  // ****************************************
  task automatic run(nad_row_t t);
    logic [10:0] a, q;
    logic [4:0]  s;
    logic [3:0]  v;
    logic        w;
    // Let the previous write-back land in the model before reading it
    @(negedge clk);
    a = {4'h0, t.m} | (t.x ? 11'h010 : 11'h000);
    q = {7'h02, t.r};
    s = nad_mem_model_i.mem[a] + (t.op[4] ? t.r : nad_mem_model_i.mem[q]) + (t.op[1] & ec);
    w = t.d && s > 5'h09;
    v = w ? s[3:0] + BCD_FIX : s[3:0];
    ec = w | s[4];
    ez = (v != 4'h0) ? 1'b0 : (t.c ? ez : 1'b1);
    {instr, cmp, dec, index_enable_flag, start} = {t.op, t.m, t.r, t.c, t.d, t.x, 1'b1};
    @(negedge clk);
    start = 0;
    chk("mem_addr", a, ma);
    if (!t.op[4]) chk("reg_addr", q, ra);
    @(negedge clk);
    chk("done", 1, done);
    chk("mem_we", !t.c && t.op[4], mwe);
    chk("reg_we", !t.c && !t.op[4], rwe);
    if (!t.c) chk("wdata", v, t.op[4] ? mwd : rwd);
    chk("flags", {ec, ez}, {cy, z});
    $display("test done op %h", t.op);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    foreach (rows[i]) run(rows[i]);
    @(negedge clk);
    {instr, start} = {16'h0800, 1'b1};
    @(negedge clk);
    start = 0;
    repeat (2) @(negedge clk);
    chk("refused", 0, {busy, done});
    $display("test done refused opcode");
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    chk("flags_reset", {CARRY_RST, ZERO_RST}, {cy, z});
    $display("test done reset");
    test_done();
  end
endmodule

// ===== testbench/nad_mem_model.sv
// Partner: data memory holding the register row, combinational read
`timescale 1ns/100ps
module nad_mem_model
  import nad_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic [DADDR_W-1:0] i_mem_addr, i_reg_addr,
  input  wire logic               i_mem_we, i_reg_we,
  input  wire logic [3:0]         i_mem_wdata, i_reg_wdata,
  output logic      [3:0]         o_mem_rdata, o_reg_rdata
);
  logic [3:0] mem [2**DADDR_W];
  // Each nibble starts as its column so expected sums are easy to pick
  initial for (int a = 0; a < 2**DADDR_W; a++) mem[a] = a[3:0];
  assign o_mem_rdata = mem[i_mem_addr];
  assign o_reg_rdata = mem[i_reg_addr];
  always @(posedge i_clock) begin
    if (i_mem_we) mem[i_mem_addr] <= i_mem_wdata;
    if (i_reg_we) mem[i_reg_addr] <= i_reg_wdata;
  end
endmodule

// ===== verilog/nad_adder.sv
// Leaf: one nibble addition, binary or decimal adjusted
`timescale 1ns/100ps
module nad_adder
  import nad_pkg::*;
(
  input  wire logic       i_a,
  input  wire logic [3:0] i_x,
  input  wire logic [3:0] i_y,
  input  wire logic       i_carry_in,
  input  wire logic       i_decimal,
  output logic      [3:0] o_sum,
  output logic            o_carry
);
  logic [4:0] raw;
  logic       bcd_over;
  logic [4:0] fixed;
  assign raw      = {1'b0, i_x} + {1'b0, i_y} + {4'h0, i_carry_in & i_a};
  assign bcd_over = raw[4] | (raw[3:0] > BCD_LIMIT);
  assign fixed    = raw + {1'b0, BCD_FIX};
  assign o_sum    = (i_decimal && bcd_over) ? fixed[3:0] : raw[3:0];
  assign o_carry  = i_decimal ? bcd_over : raw[4];
endmodule

// ===== verilog/nad_datapath.sv
// Nibble addition datapath: operand fetch, add, flag update and write-back
`timescale 1ns/100ps
// How it works
// - ADD r,m with compare clear writes register plus memory back to register.
// - Compare set suppresses write-back; carry and zero still update.
// - Carry flag set on nibble carry out, cleared otherwise.
// - Non-zero result always clears the zero flag.
// - Zero result with compare clear sets the zero flag.
// - Zero result with compare set keeps the zero flag.
// - Decimal flag selects binary or BCD; corrected sum is stored.
// - Opcode 10000 adds immediate to memory, written back to memory.
// - Opcode 00010 adds memory, register and carry into register.
// - Index enable ORs index value into the memory operand address.
// - Register field is a column; row and bank come from the pointer.
// - Index value is assembled from high, middle and low nibbles.
// - Opcode 00000 then row, column and register column fields.
module nad_datapath
  import nad_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic               i_sys_rst,
  input  wire logic               i_start,
  input  wire logic [INSTR_W-1:0] i_instr,
  input  wire logic               i_compare_flag,
  input  wire logic               i_decimal_flag,
  input  wire logic               i_index_enable_flag,
  input  wire logic [2:0]         i_index_high_nibble,
  input  wire logic [3:0]         i_index_middle_nibble,
  input  wire logic [3:0]         i_index_low_nibble,
  input  wire logic [2:0]         i_gpr_pointer_high,
  input  wire logic [3:0]         i_gpr_pointer_low,
  input  wire logic [3:0]         i_mem_rdata,
  input  wire logic [3:0]         i_reg_rdata,
  output logic                    o_busy,
  output logic                    o_done,
  output logic [DADDR_W-1:0]      o_mem_addr,
  output logic                    o_mem_we,
  output logic [3:0]              o_mem_wdata,
  output logic [DADDR_W-1:0]      o_reg_addr,
  output logic                    o_reg_we,
  output logic [3:0]              o_reg_wdata,
  output logic                    o_carry_flag,
  output logic                    o_zero_flag
);
  // ******************************
  // Decode
  // ******************************
  logic [4:0]         op;
  logic [2:0]         memory_row_field;
  logic [3:0]         memory_column_field;
  logic [3:0]         low_field;
  logic               is_add;
  logic               to_memory;
  logic               with_carry;
  logic [DADDR_W-1:0] index_register_value;
  logic [DADDR_W-1:0] operand_addr;
  logic [DADDR_W-1:0] eff_mem_addr;
  logic [DADDR_W-1:0] gpr_addr;
  logic [INSTR_W-1:0] held_instr;
  logic [4:0]         held_op;

  assign op                  = i_instr[OP_HI:OP_LO];
  assign memory_row_field    = i_instr[MROW_HI:MROW_LO];
  assign memory_column_field = i_instr[MCOL_HI:MCOL_LO];
  assign low_field           = i_instr[LOW_HI:LOW_LO];
  assign is_add     = (op == OP_ADD_RM) || (op == OP_ADD_WITH_CARRY_OPERATION_RM)
                   || (op == OP_ADD_MI) || (op == OP_ADD_WITH_CARRY_OPERATION_MI);
  // Commit-time decode reads the captured word, so a changing bus cannot steer write-back
  assign held_op    = held_instr[OP_HI:OP_LO];
  assign to_memory  = held_op[4];
  assign with_carry = held_op[1];
  // Index is 3+4+4 bits: bank in the high nibble, row and column below
  assign index_register_value = {i_index_high_nibble, i_index_middle_nibble,
                                 i_index_low_nibble};
  // Data memory bank is not part of this block; operand sits in bank zero
  assign operand_addr = {4'h0, memory_row_field, memory_column_field};
  assign eff_mem_addr = i_index_enable_flag ? (index_register_value | operand_addr)
                                            : operand_addr;
  // Pointer low bit 0 is not part of the row; bank above row above column
  assign gpr_addr = {1'b0, i_gpr_pointer_high, i_gpr_pointer_low[3:1], low_field};

  // ******************************
  // Arithmetic
  // ******************************
  logic [3:0] lhs;
  logic [3:0] sum;
  logic       carry_out;
  logic       keep_result;

  assign lhs = to_memory ? held_instr[LOW_HI:LOW_LO] : i_reg_rdata;
  assign keep_result = ~i_compare_flag;

  nad_adder nad_adder_i (
    .i_a        (with_carry),
    .i_x        (i_mem_rdata),
    .i_y        (lhs),
    .i_carry_in (o_carry_flag),
    .i_decimal  (i_decimal_flag),
    .o_sum      (sum),
    .o_carry    (carry_out)
  );

  // ******************************
  // Sequencer
  // ******************************
  // Two cycles: address out, then read data back and commit
  nad_state_t state;
  nad_state_t next_state;
  logic       take;

  // Refused requests leave the addresses and the held word alone
  assign take = (state == NAD_IDLE) && i_start && is_add;

  always_comb begin
    next_state = state;
    case (state)
      NAD_IDLE:  if (i_start && is_add) next_state = NAD_READ;
      NAD_READ:  next_state = NAD_WRITE;
      NAD_WRITE: next_state = NAD_IDLE;
      default:   next_state = NAD_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state      <= NAD_IDLE;
      held_instr <= '0;
    end else begin
      state <= next_state;
      if (take) held_instr <= i_instr;
    end
  end

  // Flags must stay stable from start until done; only the instruction word is captured
  logic commit;
  assign commit = (state == NAD_READ);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_busy       <= 1'b0;
      o_done       <= 1'b0;
      o_mem_addr   <= ADDR_RST;
      o_reg_addr   <= ADDR_RST;
      o_mem_we     <= 1'b0;
      o_reg_we     <= 1'b0;
      o_mem_wdata  <= NIB_RST;
      o_reg_wdata  <= NIB_RST;
      o_carry_flag <= CARRY_RST;
      o_zero_flag  <= ZERO_RST;
    end else begin
      o_busy   <= (next_state != NAD_IDLE);
      o_done   <= commit;
      o_mem_we <= commit && to_memory && keep_result;
      o_reg_we <= commit && !to_memory && keep_result;
      if (take) begin
        o_mem_addr <= eff_mem_addr;
        o_reg_addr <= gpr_addr;
      end
      if (commit) begin
        o_mem_wdata  <= sum;
        o_reg_wdata  <= sum;
        o_carry_flag <= carry_out;
        if (sum != 4'h0) o_zero_flag <= 1'b0;
        else if (!i_compare_flag) o_zero_flag <= 1'b1;
        // Zero with compare set keeps the flag, so chains accumulate
      end
    end
  end
endmodule
